/* File: rtl/pism_pkg.sv */
package pism_pkg;

  localparam logic [7:0] PISM_OFS_PWR_FLAGS = 8'h50;
  localparam logic [7:0] PISM_OFS_PWR_MASKS = 8'h51;
  localparam logic [7:0] PISM_OFS_PIN_FLAGS = 8'h52;
  localparam logic [7:0] PISM_OFS_PIN_MASKS = 8'h53;

  localparam logic [7:0] PISM_FLAGS_RST = 8'h00;
  localparam logic [7:0] PISM_MASKS_RST = 8'hFF;

  // field positions in the power event pair
  localparam int PISM_BIT_CLK_PERIOD = 7;
  localparam int PISM_BIT_CLK_ALARM  = 6;
  localparam int PISM_BIT_DIE_HOT    = 5;
  localparam int PISM_BIT_HOLD_RISE  = 4;
  localparam int PISM_BIT_BTN_LONG   = 3;
  localparam int PISM_BIT_BTN_PRESS  = 2;
  localparam int PISM_BIT_RESERVED   = 1;
  localparam int PISM_BIT_HOLD_FALL  = 0;

  localparam int PISM_NUM_PINS = 4;

  typedef struct packed {
    logic clock_period;
    logic clock_alarm;
    logic die_overheat;
    logic hold_rise;
    logic button_long;
    logic button_press;
    logic hold_fall;
  } pism_pwr_evt_s;

  typedef struct packed {
    logic [PISM_NUM_PINS-1:0] rise;
    logic [PISM_NUM_PINS-1:0] fall;
  } pism_pin_evt_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pism_reg_req_s;

endpackage

/* File: rtl/pism_irq_ctrl.sv */
`timescale 1ns/10ps
module pism_irq_ctrl (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    gen_rst_n,
  input  wire logic                    clk_en,
  input  wire pism_pkg::pism_reg_req_s reg_req,
  output logic [7:0]                   reg_rdata,
  input  wire pism_pkg::pism_pwr_evt_s pwr_evt,
  input  wire pism_pkg::pism_pin_evt_s pin_evt,
  output logic                         irq_out_line
);
  import pism_pkg::*;

  logic [7:0] pwr_flags_ff;
  logic [7:0] pwr_masks_ff;
  logic [7:0] pin_flags_ff;
  logic [7:0] pin_masks_ff;
  logic [7:0] rdata_ff;
  logic       irq_ff;

  wire wr_pwr_flags = reg_req.wr && reg_req.addr == PISM_OFS_PWR_FLAGS;
  wire wr_pwr_masks = reg_req.wr && reg_req.addr == PISM_OFS_PWR_MASKS;
  wire wr_pin_flags = reg_req.wr && reg_req.addr == PISM_OFS_PIN_FLAGS;
  wire wr_pin_masks = reg_req.wr && reg_req.addr == PISM_OFS_PIN_MASKS;

  logic [7:0] pwr_set;
  always_comb begin
    pwr_set = 8'h00;
    pwr_set[PISM_BIT_CLK_PERIOD] = pwr_evt.clock_period;
    pwr_set[PISM_BIT_CLK_ALARM]  = pwr_evt.clock_alarm;
    pwr_set[PISM_BIT_DIE_HOT]    = pwr_evt.die_overheat;
    pwr_set[PISM_BIT_HOLD_RISE]  = pwr_evt.hold_rise;
    pwr_set[PISM_BIT_BTN_LONG]   = pwr_evt.button_long;
    pwr_set[PISM_BIT_BTN_PRESS]  = pwr_evt.button_press;
    pwr_set[PISM_BIT_HOLD_FALL]  = pwr_evt.hold_fall;
  end

  logic [7:0] pin_set;
  for (genvar n = 0; n < PISM_NUM_PINS; n++) begin : g_pin
    assign pin_set[2*n]   = pin_evt.rise[n];
    assign pin_set[2*n+1] = pin_evt.fall[n];
  end

  // set beats a same-cycle clear so no event is lost
  wire [7:0] pwr_clr = wr_pwr_flags ? reg_req.wdata : 8'h00;
  wire [7:0] pin_clr = wr_pin_flags ? reg_req.wdata : 8'h00;
  wire [7:0] nxt_pwr_flags = (pwr_flags_ff & ~pwr_clr) | pwr_set;
  wire [7:0] nxt_pin_flags = (pin_flags_ff & ~pin_clr) | pin_set;

  // reserved mask bit stays set whatever is written
  wire [7:0] nxt_pwr_masks = reg_req.wdata | 8'h02;
  wire [7:0] eff_pwr_masks = pwr_masks_ff | 8'h02;

  // masked bits still latch above, they only drop out here
  wire [7:0] pwr_active = nxt_pwr_flags & ~eff_pwr_masks;
  wire [7:0] pin_active = nxt_pin_flags & ~pin_masks_ff;
  // next flag values so a clear drops the line in one cycle;
  // a mask write reaches the line one cycle later
  wire nxt_irq = |pwr_active | |pin_active;

  wire [7:0] nxt_rdata =
    (reg_req.addr == PISM_OFS_PWR_FLAGS) ? pwr_flags_ff :
    (reg_req.addr == PISM_OFS_PWR_MASKS) ? eff_pwr_masks :
    (reg_req.addr == PISM_OFS_PIN_FLAGS) ? pin_flags_ff :
    (reg_req.addr == PISM_OFS_PIN_MASKS) ? pin_masks_ff : 8'h00;

  // flags live only in the full-reset domain
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pwr_flags_ff <= PISM_FLAGS_RST;
      pin_flags_ff <= PISM_FLAGS_RST;
    end else if (clk_en) begin
      pwr_flags_ff <= nxt_pwr_flags;
      pin_flags_ff <= nxt_pin_flags;
    end
  end

  // masks also return to ones on the lighter general reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !gen_rst_n) begin
      pwr_masks_ff <= PISM_MASKS_RST;
      pin_masks_ff <= PISM_MASKS_RST;
    end else if (clk_en) begin
      if (wr_pwr_masks) pwr_masks_ff <= nxt_pwr_masks;
      if (wr_pin_masks) pin_masks_ff <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
      irq_ff   <= 1'b0;
    end else if (clk_en) begin
      if (reg_req.rd) rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  assign reg_rdata    = rdata_ff;
  assign irq_out_line = irq_ff;

  // flags: set, hold and clear
  sticky_flag_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && pwr_set[PISM_BIT_DIE_HOT] |=> pwr_flags_ff[PISM_BIT_DIE_HOT])
    else $error("event did not set flag");

  flag_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !wr_pwr_flags |=>
      (pwr_flags_ff & $past(pwr_flags_ff)) == $past(pwr_flags_ff))
    else $error("power flag dropped without clear");

  set_wins_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && wr_pin_flags && reg_req.wdata[2] && pin_set[2]
    |=> pin_flags_ff[2])
    else $error("same cycle clear lost an event");

  clear_one_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && wr_pin_flags && reg_req.wdata[0] && !pin_set[0]
    |=> !pin_flags_ff[0])
    else $error("write one did not clear");

  hold_zero_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && wr_pin_flags && !reg_req.wdata[3] && pin_flags_ff[3]
    |=> pin_flags_ff[3])
    else $error("write zero cleared flag");

  pwr_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && wr_pwr_flags && reg_req.wdata[PISM_BIT_CLK_PERIOD]
      && !pwr_set[PISM_BIT_CLK_PERIOD]
    |=> !pwr_flags_ff[PISM_BIT_CLK_PERIOD])
    else $error("power flag not cleared by one");

  // field positions
  reserved_zero_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !pwr_flags_ff[PISM_BIT_RESERVED])
    else $error("reserved flag set");

  alarm_pos_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && pwr_evt.clock_alarm |=> pwr_flags_ff[PISM_BIT_CLK_ALARM])
    else $error("alarm flag in wrong bit");

  pin_fall_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && pin_evt.fall[3] |=> pin_flags_ff[7])
    else $error("pin fall bit wrong");

  pin_rise_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && pin_evt.rise[2] |=> pin_flags_ff[4])
    else $error("pin rise bit wrong");

  // masking and mask registers
  masked_quiet_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && pwr_masks_ff == 8'hFF && pin_masks_ff == 8'hFF
    && $stable(pwr_masks_ff) |=> !irq_out_line)
    else $error("masked event raised line");

  masked_latch_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && pwr_masks_ff[PISM_BIT_BTN_PRESS] && pwr_evt.button_press
    |=> pwr_flags_ff[PISM_BIT_BTN_PRESS])
    else $error("masked event did not latch");

  irq_on_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && !wr_pwr_flags && pwr_flags_ff[PISM_BIT_DIE_HOT]
      && !pwr_masks_ff[PISM_BIT_DIE_HOT]
    |=> irq_out_line)
    else $error("unmasked flag did not raise line");

  rsv_read_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && reg_req.rd && reg_req.addr == PISM_OFS_PWR_MASKS
    |=> reg_rdata[PISM_BIT_RESERVED])
    else $error("reserved mask read as clear");

  pwr_mask_wr_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && gen_rst_n && wr_pwr_masks
    |=> pwr_masks_ff[PISM_BIT_RESERVED] && pwr_masks_ff[PISM_BIT_HOLD_FALL]
      == $past(reg_req.wdata[PISM_BIT_HOLD_FALL]))
    else $error("power mask write wrong");

  pin_mask_wr_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && gen_rst_n && wr_pin_masks
    |=> pin_masks_ff == $past(reg_req.wdata))
    else $error("pin mask write wrong");

  // reset domains
  masks_init_a: assert property (
    @(posedge clk_sys)
    !rst_n |=> pwr_masks_ff == PISM_MASKS_RST
      && pin_masks_ff == PISM_MASKS_RST)
    else $error("full reset left masks open");

  full_reset_a: assert property (
    @(posedge clk_sys)
    !rst_n |=> pwr_flags_ff == PISM_FLAGS_RST
      && pin_flags_ff == PISM_FLAGS_RST && !irq_out_line)
    else $error("full reset left flags or line");

  flag_keep_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !gen_rst_n && !wr_pin_flags |=>
      (pin_flags_ff & $past(pin_flags_ff)) == $past(pin_flags_ff))
    else $error("general reset touched flags");

  mask_reset_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !gen_rst_n |=> pwr_masks_ff == PISM_MASKS_RST
    && pin_masks_ff == PISM_MASKS_RST)
    else $error("general reset missed masks");

  // interrupt line
  irq_level_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> irq_out_line == $past(nxt_irq))
    else $error("line does not follow flags");

  irq_off_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && pwr_flags_ff == 8'h00 && pin_flags_ff == 8'h00
      && pwr_set == 8'h00 && pin_set == 8'h00
    |=> !irq_out_line)
    else $error("line active with no flag");

  freeze_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !clk_en && gen_rst_n |=> $stable(pwr_flags_ff) && $stable(pin_flags_ff)
      && $stable(pwr_masks_ff) && $stable(pin_masks_ff)
      && $stable(irq_out_line) && $stable(reg_rdata))
    else $error("state moved while clock enable low");

endmodule

/* File: tb/tb.sv */
`timescale 1ns/10ps
module tb;
  import pism_pkg::*;
  logic          clk_sys   = 1'b0;
  logic          rst_n     = 1'b0;
  logic          gen_rst_n = 1'b1;
  logic          clk_en    = 1'b1;
  pism_reg_req_s req       = '0;
  pism_pwr_evt_s pwr       = '0;
  pism_pin_evt_s pin       = '0;
  logic [7:0]    rdata;
  logic          irq;
  int            err_count   = 0;
  int            check_count = 0;
  // address, write data, expected readback
  logic [23:0]   rows [6] = '{24'h510002, 24'h51FFFF, 24'h535A5A,
                              24'h53FFFF, 24'h50FF00, 24'h605A00};

  always #2.5 clk_sys = ~clk_sys;

  pism_irq_ctrl pism_irq_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .gen_rst_n(gen_rst_n), .clk_en(clk_en), .reg_req(req),
    .reg_rdata(rdata), .pwr_evt(pwr), .pin_evt(pin), .irq_out_line(irq));

  task automatic chk8(input string nm, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_sys) req = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys) req = '0;
  endtask

  task automatic rc(input logic [7:0] a, e);
    @(negedge clk_sys) req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys) req = '0;
    chk8("rdata", e, rdata);
  endtask

  // extra idle cycle lets the registered line settle
  task automatic ev(input pism_pwr_evt_s p, input pism_pin_evt_s q);
    @(negedge clk_sys) pwr = p;
    pin = q;
    @(negedge clk_sys) pwr = '0;
    pin = '0;
    @(negedge clk_sys);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    stop_test();
  end

  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    rc(8'h50, 8'h00);
    rc(8'h51, 8'hFF);
    rc(8'h52, 8'h00);
    rc(8'h53, 8'hFF);
    foreach (rows[r]) begin
      wr(rows[r][23:16], rows[r][15:8]);
      rc(rows[r][23:16], rows[r][7:0]);
    end
    for (int i = 0; i < 7; i++) begin
      ev(7'(1 << i), '0);
      chk1("irq", 1'b0, irq);
      rc(8'h50, i == 0 ? 8'h01 : 8'(2 << i));
      wr(8'h50, 8'h00);
      rc(8'h50, i == 0 ? 8'h01 : 8'(2 << i));
      wr(8'h50, 8'hFF);
      rc(8'h50, 8'h00);
    end
    for (int n = 0; n < 4; n++) begin
      ev('0, {4'(1 << n), 4'h0});
      ev('0, {4'h0, 4'(1 << n)});
      rc(8'h52, 8'(3 << (2 * n)));
      wr(8'h52, 8'hFF);
    end
    // unmask only the overheat source
    wr(8'h51, 8'hDF);
    ev(7'h10, '0);
    chk1("irq", 1'b1, irq);
    // mask writes reach the line one cycle after they land
    wr(8'h51, 8'hFF);
    @(negedge clk_sys);
    chk1("irq", 1'b0, irq);
    wr(8'h51, 8'hDF);
    @(negedge clk_sys);
    chk1("irq", 1'b1, irq);
    wr(8'h50, 8'h20);
    chk1("irq", 1'b0, irq);
    ev('0, 8'h10);
    wr(8'h53, 8'hFE);
    @(negedge clk_sys);
    chk1("irq", 1'b1, irq);
    @(negedge clk_sys) gen_rst_n = 1'b0;
    @(negedge clk_sys) gen_rst_n = 1'b1;
    rc(8'h53, 8'hFF);
    rc(8'h51, 8'hFF);
    rc(8'h52, 8'h01);
    chk1("irq", 1'b0, irq);
    @(negedge clk_sys) rst_n = 1'b0;
    @(negedge clk_sys) rst_n = 1'b1;
    rc(8'h52, 8'h00);
    // frozen clock enable: event and write are both lost
    @(negedge clk_sys) clk_en = 1'b0;
    ev('0, 8'h80);
    wr(8'h53, 8'h00);
    @(negedge clk_sys) clk_en = 1'b1;
    rc(8'h52, 8'h00);
    rc(8'h53, 8'hFF);
    chk1("irq", 1'b0, irq);
    // event and clear in one cycle: the event survives
    @(negedge clk_sys) req = '{1'b1, 1'b0, 8'h52, 8'hFF};
    pin = 8'h20;
    @(negedge clk_sys) req = '0;
    pin = '0;
    rc(8'h52, 8'h04);
    stop_test();
  end
endmodule
